// >>> pkg/bcie_pkg.sv
package bcie_pkg;
	localparam int IR_W = 12;
	localparam int PC_W = 11;
	localparam int FILE_N = 32;
	localparam int WDT_W = 8;
	localparam int PRE_W = 8;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_WORK = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0C;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam logic [7:0] OFS_DIR6 = 8'h14;
	localparam logic [7:0] OFS_DIR7 = 8'h18;
	localparam logic [7:0] OFS_STATE = 8'h1C;
	localparam logic [7:0] OFS_WDT = 8'h20;
	localparam logic [7:0] OFS_FILE = 8'h80;

	// control bit positions in the state register
	localparam int ST_SLEEP_BIT = 0;
	localparam int ST_BUSY_BIT = 1;

	localparam logic [2:0] DIR_SEL6 = 3'h6;
	localparam logic [2:0] DIR_SEL7 = 3'h7;

	// reset values
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_CONFIG = 8'hFF;
	localparam logic [7:0] RST_STATUS = 8'h18;

	// bit 7..0 of the status byte
	typedef struct packed {
		logic pin_change_wake_flag;
		logic [1:0] page;
		logic timeout_flag;
		logic powerdown_flag;
		logic zero;
		logic digit_carry_flag;
		logic carry;
	} bcie_status_t;

	typedef enum logic [4:0] {
		OPC_NOP, OPC_CONFIG, OPC_SLEEP, OPC_DIR, OPC_STORE, OPC_SUB, OPC_OR_F, OPC_XOR_F,
		OPC_MOVE, OPC_RRC, OPC_RLC, OPC_SWAP, OPC_INCSKIP, OPC_RETLIT, OPC_CALL,
		OPC_BRANCH, OPC_LOADLIT, OPC_OR_LIT, OPC_XOR_LIT
	} bcie_op_t;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH, ST_SLEEP} bcie_state_t;

	function automatic bcie_op_t bcie_decode(input logic [IR_W-1:0] ir);
		bcie_op_t op;
		op = OPC_NOP;
		casez (ir)
			12'b0000_0000_0010: op = OPC_CONFIG;
			12'b0000_0000_0011: op = OPC_SLEEP;
			12'b0000_0000_011?: op = OPC_DIR;
			12'b0000_001?_????: op = OPC_STORE;
			12'b0000_10??_????: op = OPC_SUB;
			12'b0001_00??_????: op = OPC_OR_F;
			12'b0001_10??_????: op = OPC_XOR_F;
			12'b0010_00??_????: op = OPC_MOVE;
			12'b0011_00??_????: op = OPC_RRC;
			12'b0011_01??_????: op = OPC_RLC;
			12'b0011_10??_????: op = OPC_SWAP;
			12'b0011_11??_????: op = OPC_INCSKIP;
			12'b1000_????_????: op = OPC_RETLIT;
			12'b1001_????_????: op = OPC_CALL;
			12'b101?_????_????: op = OPC_BRANCH;
			12'b1100_????_????: op = OPC_LOADLIT;
			12'b1101_????_????: op = OPC_OR_LIT;
			12'b1111_????_????: op = OPC_XOR_LIT;
			default: op = OPC_NOP;
		endcase
		return op;
	endfunction
endpackage

// >>> rtl/bcie_core.sv
// What this block does
// RQ1: increment file, skip next when result zero
// RQ2: branch loads nine bits, page from status
// RQ3: or literal into working, update zero
// RQ4: or working with file, update zero
// RQ5: destination bit zero working, one file
// RQ6: store working into file, flags untouched
// RQ7: move file to destination, update zero
// RQ8: load literal into working, no flags
// RQ9: working copied into timer configuration register
// RQ10: return loads literal, pops stack, two cycles
// RQ11: sleep clears watchdog, sets timeout, clears powerdown
// RQ12: rotate left through carry
// RQ13: rotate right through carry
// RQ14: subtract working from file, update C DC Z
// RQ15: swap nibbles, no flags changed
// RQ16: working copied into direction latch six/seven
// RQ17: xor working with file, update zero
// RQ18: xor literal into working, update zero
// RQ19: call pushes return, loads low eight bits
// RQ20: zero flag set exactly when result zero
// RQ21: subtract carry means no borrow
//
// The APB interface to the registers and the address map were decided locally.
module bcie_core import bcie_pkg::*; #(
	parameter int FILES = FILE_N
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic sleeping
);
	bcie_state_t st_r;
	logic [IR_W-1:0] ir_r;
	logic [7:0] work_r;
	bcie_status_t status_r;
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] stk0_r;
	logic [PC_W-1:0] stk1_r;
	logic [7:0] config_r;
	logic [7:0] dir6_r;
	logic [7:0] dir7_r;
	logic [PRE_W-1:0] prescale_r;
	logic [WDT_W-1:0] watchdog_counter_r;
	logic [7:0] file_r [FILES];

	logic acc;
	logic wr;
	logic mapped;
	logic file_hit;
	logic [4:0] fa;
	bcie_op_t op;
	logic [7:0] fv;
	logic [7:0] lit;
	logic dest_file;
	logic [7:0] res;
	logic res_valid;
	logic upd_z;
	logic upd_c;
	logic new_c;
	logic new_dc;
	logic two_cycle;
	logic [8:0] diff;
	logic exec;

	assign exec = st_r == ST_EXEC;
	// bus waits while an instruction is in flight
	assign pready = st_r == ST_IDLE || st_r == ST_SLEEP;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && pstrb[0];
	assign file_hit = paddr >= OFS_FILE;
	assign fa = ir_r[4:0];
	assign op = bcie_decode(ir_r);
	assign fv = file_r[fa];
	assign lit = ir_r[7:0];
	assign dest_file = ir_r[5]; // [RQ5]
	assign sleeping = st_r == ST_SLEEP;
	assign diff = {1'b0, fv} - {1'b0, work_r};

	always_comb begin
		res = fv;
		res_valid = 1'b1;
		upd_z = 1'b0;
		upd_c = 1'b0;
		new_c = status_r.carry;
		new_dc = status_r.digit_carry_flag;
		two_cycle = 1'b0;
		unique case (op)
			OPC_OR_F: begin
				res = work_r | fv; // [RQ4]
				upd_z = 1'b1;
			end
			OPC_XOR_F: begin
				res = work_r ^ fv; // [RQ17]
				upd_z = 1'b1;
			end
			OPC_MOVE: upd_z = 1'b1; // [RQ7]
			OPC_SWAP: res = {fv[3:0], fv[7:4]}; // [RQ15]
			OPC_RLC: begin
				res = {fv[6:0], status_r.carry}; // [RQ12]
				new_c = fv[7];
				upd_c = 1'b1;
			end
			OPC_RRC: begin
				res = {status_r.carry, fv[7:1]}; // [RQ13]
				new_c = fv[0];
				upd_c = 1'b1;
			end
			OPC_SUB: begin
				res = diff[7:0]; // [RQ14]
				new_c = ~diff[8]; // [RQ21]
				new_dc = fv[3:0] >= work_r[3:0]; // [RQ21]
				upd_c = 1'b1;
				upd_z = 1'b1;
			end
			OPC_INCSKIP: begin
				res = fv + 8'h01; // [RQ1]
				two_cycle = res == 8'h00;
			end
			OPC_RETLIT, OPC_CALL, OPC_BRANCH: begin
				res_valid = 1'b0;
				two_cycle = 1'b1; // [RQ2] [RQ10]
			end
			default: res_valid = 1'b0;
		endcase
	end

	// core sequencing; a skip or branch spends one extra cycle as a no-op
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_IDLE;
			ir_r <= '0;
		end else begin
			unique case (st_r)
				ST_IDLE: begin
					if (wr && paddr == OFS_INSTR) begin
						ir_r <= pwdata[IR_W-1:0];
						st_r <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (op == OPC_SLEEP)
						st_r <= ST_SLEEP; // [RQ11]
					else if (two_cycle)
						st_r <= ST_FLUSH; // [RQ1]
					else
						st_r <= ST_IDLE;
				end
				ST_FLUSH: st_r <= ST_IDLE;
				ST_SLEEP: begin
					// instruction writes are dropped until software wakes the core
					if (wr && paddr == OFS_STATE && pwdata[ST_SLEEP_BIT])
						st_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_r <= '0;
		end else if (exec) begin
			if (res_valid && !dest_file)
				work_r <= res; // [RQ5]
			else if (op == OPC_LOADLIT || op == OPC_RETLIT)
				work_r <= lit; // [RQ8] [RQ10]
			else if (op == OPC_OR_LIT)
				work_r <= work_r | lit; // [RQ3]
			else if (op == OPC_XOR_LIT)
				work_r <= work_r ^ lit; // [RQ18]
		end else if (wr && paddr == OFS_WORK) begin
			work_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= bcie_status_t'(RST_STATUS);
		end else if (exec) begin
			if (upd_z)
				status_r.zero <= res == 8'h00; // [RQ20]
			else if (op == OPC_OR_LIT)
				status_r.zero <= (work_r | lit) == 8'h00; // [RQ20]
			else if (op == OPC_XOR_LIT)
				status_r.zero <= (work_r ^ lit) == 8'h00; // [RQ20]
			if (upd_c)
				status_r.carry <= new_c;
			if (op == OPC_SUB)
				status_r.digit_carry_flag <= new_dc;
			if (op == OPC_SLEEP) begin
				status_r.timeout_flag <= 1'b1; // [RQ11]
				status_r.powerdown_flag <= 1'b0; // [RQ11]
			end
		end else if (wr && paddr == OFS_STATUS) begin
			status_r <= bcie_status_t'(pwdata[7:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_r <= '0;
			stk0_r <= '0;
			stk1_r <= '0;
		end else if (exec) begin
			unique case (op)
				OPC_BRANCH: pc_r <= {status_r.page, ir_r[8:0]}; // [RQ2]
				OPC_CALL: begin
					stk0_r <= pc_r + 11'h001; // [RQ19]
					stk1_r <= stk0_r;
					pc_r <= {status_r.page, 1'b0, lit}; // [RQ19]
				end
				OPC_RETLIT: begin
					pc_r <= stk0_r; // [RQ10]
					stk0_r <= stk1_r;
				end
				default: pc_r <= two_cycle ? pc_r + 11'h002 : pc_r + 11'h001; // [RQ1]
			endcase
		end else if (wr && paddr == OFS_PC) begin
			pc_r <= pwdata[PC_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_r <= RST_CONFIG;
			dir6_r <= RST_DIR;
			dir7_r <= RST_DIR;
		end else if (exec) begin
			if (op == OPC_CONFIG)
				config_r <= work_r; // [RQ9]
			if (op == OPC_DIR && ir_r[2:0] == DIR_SEL6)
				dir6_r <= work_r; // [RQ16]
			if (op == OPC_DIR && ir_r[2:0] == DIR_SEL7)
				dir7_r <= work_r; // [RQ16]
		end
	end

	// watchdog keeps counting; only the sleep entry clears it here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_r <= '0;
			watchdog_counter_r <= '0;
		end else if (exec && op == OPC_SLEEP) begin
			prescale_r <= '0; // [RQ11]
			watchdog_counter_r <= '0; // [RQ11]
		end else begin
			prescale_r <= prescale_r + 1'b1;
			if (&prescale_r)
				watchdog_counter_r <= watchdog_counter_r + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < FILES; i++)
				file_r[i] <= '0;
		end else if (exec) begin
			if (op == OPC_STORE)
				file_r[fa] <= work_r; // [RQ6]
			else if (res_valid && dest_file)
				file_r[fa] <= res; // [RQ5]
		end else if (wr && file_hit) begin
			file_r[paddr[6:2]] <= pwdata[7:0];
		end
	end

	always_comb begin
		mapped = 1'b1;
		prdata = '0;
		if (file_hit) begin
			prdata[7:0] = file_r[paddr[6:2]];
		end else begin
			unique case (paddr)
				OFS_INSTR: prdata[IR_W-1:0] = ir_r;
				OFS_WORK: prdata[7:0] = work_r;
				OFS_STATUS: prdata[7:0] = status_r;
				OFS_PC: prdata[PC_W-1:0] = pc_r;
				OFS_CONFIG: prdata[7:0] = config_r;
				OFS_DIR6: prdata[7:0] = dir6_r;
				OFS_DIR7: prdata[7:0] = dir7_r;
				OFS_STATE: begin
					prdata[ST_SLEEP_BIT] = st_r == ST_SLEEP;
					prdata[ST_BUSY_BIT] = !pready;
				end
				OFS_WDT: prdata[WDT_W-1:0] = watchdog_counter_r;
				default: mapped = 1'b0;
			endcase
		end
		pslverr = acc && !mapped;
	end

	a_swap_result: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
		exec && op == OPC_SWAP && !dest_file |=> work_r == {$past(fv[3:0]), $past(fv[7:4])} &&
		status_r == $past(status_r))
		else $error("swap result or flags wrong");
	a_skip_flush: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
		exec && op == OPC_INCSKIP && fv == 8'hFF |=> st_r == ST_FLUSH ##1 st_r == ST_IDLE)
		else $error("zero increment did not skip");
	a_branch_pc: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
		exec && op == OPC_BRANCH |=> pc_r == {$past(status_r.page), $past(ir_r[8:0])} && !pready)
		else $error("branch target wrong");
	a_sub_flags: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
		exec && op == OPC_SUB |=> status_r.carry == ($past(fv) >= $past(work_r)) &&
		status_r.zero == ($past(fv) == $past(work_r)))
		else $error("subtract flags wrong");
	a_sleep_flags: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
		exec && op == OPC_SLEEP |=> status_r.timeout_flag && !status_r.powerdown_flag &&
		watchdog_counter_r == '0 && st_r == ST_SLEEP &&
		status_r.pin_change_wake_flag == $past(status_r.pin_change_wake_flag))
		else $error("sleep side effects wrong");
	a_rotl_carry: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
		exec && op == OPC_RLC && dest_file |=> status_r.carry == $past(fv[7]) &&
		file_r[$past(fa)] == {$past(fv[6:0]), $past(status_r.carry)})
		else $error("rotate left wrong");
	a_return_pop: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
		exec && op == OPC_RETLIT |=> pc_r == $past(stk0_r) && work_r == $past(lit) ##1 pready)
		else $error("return wrong");
	a_call_push: assert property (@(posedge pclk) disable iff (!presetn) // [RQ19]
		exec && op == OPC_CALL |=> stk0_r == $past(pc_r) + 11'h001 && pc_r[8] == 1'b0)
		else $error("call wrong");
	a_xorlit_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RQ18]
		exec && op == OPC_XOR_LIT |=> status_r.zero == (work_r == 8'h00))
		else $error("xor literal zero flag wrong");
	a_dir_load: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
		exec && op == OPC_DIR && ir_r[2:0] == DIR_SEL7 |=> dir7_r == $past(work_r) &&
		status_r == $past(status_r))
		else $error("direction latch load wrong");
	a_dir6_load: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
		exec && op == OPC_DIR && ir_r[2:0] == DIR_SEL6 |=> dir6_r == $past(work_r) && dir7_r == $past(dir7_r))
		else $error("direction latch six load wrong");
	a_orlit_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
		exec && op == OPC_OR_LIT |=> work_r == ($past(work_r) | $past(lit)) &&
		status_r.zero == (work_r == 8'h00))
		else $error("or literal result wrong");
	a_orfile_dest: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
		exec && op == OPC_OR_F && !dest_file |=> work_r == ($past(work_r) | $past(fv)) &&
		status_r.zero == (work_r == 8'h00))
		else $error("or with file result wrong");
	a_store_file: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
		exec && op == OPC_STORE |=> file_r[$past(fa)] == $past(work_r) && status_r == $past(status_r))
		else $error("store working wrong");
	a_loadlit_flags: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
		exec && op == OPC_LOADLIT |=> work_r == $past(lit) && status_r == $past(status_r))
		else $error("load literal wrong");
	a_config_load: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
		exec && op == OPC_CONFIG |=> config_r == $past(work_r) && status_r == $past(status_r))
		else $error("configuration load wrong");
	a_rotr_carry: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
		exec && op == OPC_RRC && !dest_file |=> status_r.carry == $past(fv[0]) &&
		work_r == {$past(status_r.carry), $past(fv[7:1])})
		else $error("rotate right wrong");
	a_xorfile_dest: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
		exec && op == OPC_XOR_F && dest_file |=> file_r[$past(fa)] == ($past(work_r) ^ $past(fv)) &&
		work_r == $past(work_r))
		else $error("xor with file result wrong");
	a_move_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
		exec && op == OPC_MOVE |=> status_r.zero == ($past(fv) == 8'h00))
		else $error("move zero flag wrong");
	a_sub_digit: assert property (@(posedge pclk) disable iff (!presetn) // [RQ21]
		exec && op == OPC_SUB |=> status_r.digit_carry_flag == ($past(fv[3:0]) >= $past(work_r[3:0])))
		else $error("subtract digit carry wrong");
	a_incskip_plain: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
		exec && op == OPC_INCSKIP && fv != 8'hFF |=> st_r == ST_IDLE && status_r == $past(status_r))
		else $error("increment without skip wrong");

	c_skip: cover property (@(posedge pclk) disable iff (!presetn) exec && op == OPC_INCSKIP && two_cycle);
	c_branch: cover property (@(posedge pclk) disable iff (!presetn) exec && op == OPC_BRANCH);
	c_sub_borrow: cover property (@(posedge pclk) disable iff (!presetn) exec && op == OPC_SUB && diff[8]);
	c_sleep_wake: cover property (@(posedge pclk) disable iff (!presetn) st_r == ST_SLEEP ##[1:20] st_r == ST_IDLE);
	c_call_ret: cover property (@(posedge pclk) disable iff (!presetn)
		exec && op == OPC_CALL ##[2:40] exec && op == OPC_RETLIT);
endmodule // bcie_core

// >>> sim/bcie_core_bench.sv
module bcie_core_bench import bcie_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sleeping;
	logic slp = 1'b0;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	logic [33:0] exp_q[$];
	logic [5:0] ops[9] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0C, 6'h0D, 6'h0E, 6'h0F};
	logic [3:0] lops[3] = '{4'hC, 4'hD, 4'hF};

	always #25 pclk = ~pclk;

	bcie_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleeping(sleeping));

	task automatic complete_run;
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles > 20000) begin
			errors++;
			complete_run;
		end
	end

	// read at the accepting edge, before that edge's updates land
	always @(posedge pclk) begin
		logic [33:0] e;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = exp_q.pop_front();
			checked++;
			if ({sleeping, pslverr, prdata} !== e) begin
				errors++;
				$display("MISMATCH read %h expected %h seen %h", paddr, e, {sleeping, pslverr, prdata});
			end
		end
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
		exp_q.push_back({slp, err, e});
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic ex(input logic [11:0] ins);
		wr(OFS_INSTR, {20'h0, ins});
	endtask

	task automatic fop(input logic [5:0] p, input logic d, input logic [7:0] fv, input logic [7:0] w);
		logic [4:0] f;
		logic [7:0] s, r, ns, fa;
		logic [10:0] pc, npc;
		logic fd;
		f = 5'($urandom);
		fa = OFS_FILE + {1'b0, f, 2'b00};
		s = {1'b0, 2'($urandom), 2'b11, 3'($urandom)};
		pc = 11'($urandom);
		fd = d | (p == 6'h00);
		ns = s;
		r = fv;
		case (p)
			6'h00: r = w;
			6'h02: begin
				r = fv - w;
				ns[0] = fv >= w;
				ns[1] = fv[3:0] >= w[3:0];
			end
			6'h04: r = fv | w;
			6'h06: r = fv ^ w;
			6'h0C: begin
				r = {s[0], fv[7:1]};
				ns[0] = fv[0];
			end
			6'h0D: begin
				r = {fv[6:0], s[0]};
				ns[0] = fv[7];
			end
			6'h0E: r = {fv[3:0], fv[7:4]};
			6'h0F: r = fv + 8'h01;
			default: ;
		endcase
		if (p inside {6'h02, 6'h04, 6'h06, 6'h08})
			ns[2] = (r == 8'h00);
		npc = pc + ((p == 6'h0F && r == 8'h00) ? 11'd2 : 11'd1);
		wr(OFS_WORK, {24'h0, w});
		wr(OFS_STATUS, {24'h0, s});
		wr(OFS_PC, {21'h0, pc});
		wr(fa, {24'h0, fv});
		ex({p, fd, f});
		rd(OFS_WORK, {24'h0, fd ? w : r});
		rd(fa, {24'h0, fd ? r : fv});
		rd(OFS_STATUS, {24'h0, ns});
		rd(OFS_PC, {21'h0, npc});
	endtask

	task automatic lit(input logic [3:0] op, input logic [7:0] w, input logic [7:0] k);
		logic [7:0] s, r;
		logic [10:0] pc;
		s = {1'b0, 2'($urandom), 2'b11, 3'($urandom)};
		pc = 11'($urandom);
		r = (op == 4'hC) ? k : (op == 4'hD) ? (w | k) : (w ^ k);
		wr(OFS_WORK, {24'h0, w});
		wr(OFS_STATUS, {24'h0, s});
		wr(OFS_PC, {21'h0, pc});
		ex({op, k});
		if (op != 4'hC)
			s[2] = (r == 8'h00);
		rd(OFS_WORK, {24'h0, r});
		rd(OFS_STATUS, {24'h0, s});
		rd(OFS_PC, {21'h0, 11'(pc + 11'd1)});
	endtask

	initial begin
		logic [7:0] k;
		k = 8'($urandom(50476));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STATUS, {24'h0, RST_STATUS});
		rd(OFS_CONFIG, {24'h0, RST_CONFIG});
		rd(OFS_DIR6, {24'h0, RST_DIR});
		rd(OFS_DIR7, {24'h0, RST_DIR});
		rd(8'h40, 32'h0, 1'b1);
		for (int i = 0; i < 9; i++)
			for (int d = 0; d < 2; d++)
				repeat (4) fop(ops[i], d[0], 8'($urandom), 8'($urandom));
		fop(6'h02, 1'b0, 8'h35, 8'h35);
		fop(6'h02, 1'b1, 8'h10, 8'h01);
		fop(6'h0F, 1'b1, 8'hFF, 8'h00);
		fop(6'h06, 1'b0, 8'h5A, 8'h5A);
		fop(6'h08, 1'b1, 8'h00, 8'h33);
		fop(6'h04, 1'b0, 8'h00, 8'h00);
		for (int i = 0; i < 3; i++) begin
			repeat (3) lit(lops[i], 8'($urandom), 8'($urandom));
			lit(lops[i], 8'h00, 8'h00);
		end
		lit(4'hF, 8'hA7, 8'hA7);
		// page bits 10 reach the upper pc bits on branch and call
		wr(OFS_STATUS, 32'h40);
		wr(OFS_PC, 32'h123);
		ex(12'hBA5);
		rd(OFS_PC, 32'h5A5);
		ex({4'h9, k});
		rd(OFS_PC, {21'h0, 3'b100, k});
		ex(12'h87E);
		rd(OFS_WORK, 32'h7E);
		rd(OFS_PC, 32'h5A6);
		for (int i = 0; i < 3; i++) begin
			k = 8'($urandom);
			wr(OFS_WORK, {24'h0, k});
			wr(OFS_STATUS, 32'h1F);
			ex(i == 0 ? 12'h002 : 12'(5 + i));
			rd(OFS_CONFIG + 8'(4 * i), {24'h0, k});
			rd(OFS_STATUS, 32'h1F);
		end
		wr(OFS_WORK, 32'h12);
		wr(OFS_STATUS, 32'h8F);
		ex(12'h003);
		slp = 1'b1;
		rd(OFS_STATUS, 32'h97);
		rd(OFS_WDT, 32'h0);
		rd(OFS_STATE, 32'h1);
		ex(12'hC34);
		rd(OFS_WORK, 32'h12);
		wr(OFS_STATE, 32'h1);
		slp = 1'b0;
		rd(OFS_STATE, 32'h0);
		complete_run;
	end
endmodule // bcie_core_bench
